// >>> pkg/csdp_pkg.sv
/*
 * Constants and carrier types for the channel status, FIFO data port and
 * input DMA pointer logic of one link channel.
 * Assumes one system clock and a simple strobed register port.
 */
`default_nettype none

package csdp_pkg;

	// register port address width and channel-zero offsets
	localparam int ADDR_W = 9;
	localparam logic [ADDR_W-1:0] OFS_CHAN_STATUS = 9'h024;
	localparam logic [ADDR_W-1:0] OFS_FIFO_DATA = 9'h028;
	localparam logic [ADDR_W-1:0] OFS_DMA_PTR = 9'h02C;

	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] LATCH_MASK = 32'h003F_FF00;

	// latched status bit positions
	localparam int B_TX_AE_L = 8;
	localparam int B_RX_AF_L = 9;
	localparam int B_RX_OVF = 10;
	localparam int B_SYM_ERR = 11;
	localparam int B_WR_DMA_DONE = 12;
	localparam int B_RD_DMA_DONE = 13;
	localparam int B_WR_DMA_ERR = 14;
	localparam int B_RD_DMA_ERR = 15;
	localparam int B_RX_READY = 18;
	localparam int B_TX_DREAD = 19;
	localparam int B_TX_FDONE = 20;
	localparam int B_RX_FDONE = 21;

	localparam logic [1:0] TX_IO_MAX = 2'h2;

	// descriptor next-pointer flags and word count
	localparam int DESC_EOC_BIT = 0;
	localparam int DESC_DIR_BIT = 1;
	localparam logic DESC_DIR_INPUT = 1'b0;
	localparam logic [1:0] DESC_LAST_WORD = 2'h2;
	localparam logic [31:0] DESC_ADDR_MASK = 32'hFFFF_FFFC;

	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL_CNT = 2'h2;

	// one-cycle event pulses from the link and the output DMA engine
	typedef struct packed {
		logic rx_viol;
		logic rx_ready;
		logic tx_data_read;
		logic tx_frame_done;
		logic rx_frame_done;
		logic rx_wr_attempt;
		logic rd_dma_done;
		logic rd_dma_err;
	} csdp_evt_t;

	// live levels from the FIFOs, link machines and interrupt logic
	typedef struct packed {
		logic [13:0] tx_count;
		logic [13:0] tx_ae_level;
		logic tx_full;
		logic tx_stage_valid;
		logic tx_fifo_out_valid;
		logic [1:0] tx_io_cnt;
		logic [14:0] rx_count;
		logic [14:0] rx_af_level;
		logic rx_full;
		logic [2:0] rx_stage_cnt;
		logic rx_running;
		logic rx_io_full;
		logic aux_full;
		logic aux_afull;
		logic aux_empty;
		logic rd_dma_idle;
		logic user_irq;
		logic chan_irq;
	} csdp_live_t;

	typedef enum logic [2:0] {
		DMA_IDLE = 3'b001,
		DMA_FETCH = 3'b010,
		DMA_MOVE = 3'b100
	} csdp_dma_state_t;

endpackage

`default_nettype wire

// >>> verilog/csdp_channel_regs.sv
/*
 * Channel status register, single-word FIFO data port and input DMA
 * pointer port with its scatter-gather descriptor engine.
 * Assumes the FIFOs, link machines, bus master and output DMA sit outside
 * and report through the live and event ports; one clock, strobed port.
 * Live inputs are settled levels at every clock edge, events are
 * one-cycle pulses, and descriptor and block answers are one-cycle
 * pulses given while the matching request stands.
 */
// How it works
// - status bits 0-2 show tx FIFO empty, at-or-below threshold, full
// - status bits 4-6 show rx FIFO empty, at-or-above threshold, full
// - bit 3 set while any tx word remains, stage included
// - bit 7 set while any rx word remains, four-word stage included
// - bit 8 latches when tx count falls to threshold; write one clears
// - bit 9 latches when rx count reaches threshold; write one clears
// - bit 10 latches a write attempt into a full rx FIFO
// - bit 11 latches the violation symbol flag of the receiver
// - bits 12 and 13 latch input and output DMA list completion
// - bits 14 and 15 latch DMA errors or wrong direction; an input DMA abort latches nothing
// - bits 16 and 17 read one while the input and output DMA engines are idle
// - bits 18 and 19 latch receiver ready and transmitter read pulses
// - bit 20 latches transmit frame done
// - bit 21 latches receive frame done from stop sequence or count
// - bit 22 reads one while the receiver processes a frame
// - bit 23 reads one while the receiver sample FIFO is full
// - bit 27 reads one while the tx FIFO output holds valid data
// - bits 29-28 give tx words in process, clamped to two
// - bit 30 shows an enabled non-DMA user interrupt is active
// - bit 31 shows the channel interrupt output is active
// - data port write pushes tx FIFO while o_wr_ready is high, read pops rx FIFO
// - nonzero pointer write while idle starts descriptor chain DMA; zero aborts it
// - status reads at 0x024; written ones clear latched bits
`timescale 1ns/1ps
`default_nettype none

module csdp_channel_regs
	import csdp_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_wr_ready,
	// live levels and event pulses
	input wire csdp_live_t i_live,
	input wire csdp_evt_t i_evt,
	// tx FIFO write side
	output logic o_tx_valid,
	output logic [31:0] o_tx_data,
	input wire logic i_tx_ready,
	// rx FIFO read side
	input wire logic i_rx_valid,
	input wire logic [31:0] i_rx_data,
	output logic o_rx_pop,
	// descriptor fetch
	output logic o_desc_req,
	output logic [31:0] o_desc_addr,
	input wire logic i_desc_ack,
	input wire logic [31:0] i_desc_data,
	input wire logic i_desc_err,
	// block transfer into host memory
	output logic o_blk_req,
	output logic [31:0] o_blk_addr,
	output logic [31:0] o_blk_len,
	input wire logic i_blk_done,
	input wire logic i_blk_err,
	output logic o_wr_dma_idle
);

	logic wr_status;
	logic wr_fifo;
	logic wr_ptr;
	logic rd_status;
	logic rd_fifo;
	logic [31:0] latch_q;
	logic [31:0] latch_set;
	logic [31:0] latch_clr;
	logic [31:0] status_live;
	logic [31:0] status_word;
	logic tx_ae_now;
	logic rx_af_now;
	logic tx_ae_q;
	logic rx_af_q;
	logic [31:0] buf_mem_q [BUF_DEPTH];
	logic buf_wr_idx_q;
	logic buf_rd_idx_q;
	logic [1:0] buf_cnt_q;
	logic buf_push;
	logic buf_pop;
	csdp_dma_state_t dma_state_q;
	logic [1:0] word_idx_q;
	logic [31:0] next_ptr_q;
	logic last_desc_q;
	logic dma_done_pulse;
	logic dma_err_pulse;
	logic dma_abort;
	logic dma_start;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [1:0] clamp_io(input logic [1:0] n);
		clamp_io = (n > TX_IO_MAX) ? TX_IO_MAX : n;
	endfunction

	// address decode
	always_comb begin
		wr_status = 1'b0;
		wr_fifo = 1'b0;
		wr_ptr = 1'b0;
		rd_status = 1'b0;
		rd_fifo = 1'b0;
		if (hit(i_reg_addr, OFS_CHAN_STATUS)) begin
			wr_status = i_reg_wr;
			rd_status = i_reg_rd;
		end else if (hit(i_reg_addr, OFS_FIFO_DATA)) begin
			wr_fifo = i_reg_wr & o_wr_ready;
			rd_fifo = i_reg_rd;
		end else if (hit(i_reg_addr, OFS_DMA_PTR)) begin
			wr_ptr = i_reg_wr;
		end
	end

	// threshold compares feed both live and latched bits
	assign tx_ae_now = (i_live.tx_count <= i_live.tx_ae_level);
	assign rx_af_now = (i_live.rx_count >= i_live.rx_af_level);

	// the edge memory resets low, so a level already true latches once
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_ae_q <= 1'b0;
			rx_af_q <= 1'b0;
		end else begin
			tx_ae_q <= tx_ae_now;
			rx_af_q <= rx_af_now;
		end
	end

	always_comb begin
		latch_set = '0;
		latch_set[B_TX_AE_L] = tx_ae_now & ~tx_ae_q;
		latch_set[B_RX_AF_L] = rx_af_now & ~rx_af_q;
		latch_set[B_RX_OVF] = i_evt.rx_wr_attempt & i_live.rx_full;
		latch_set[B_SYM_ERR] = i_evt.rx_viol;
		latch_set[B_WR_DMA_DONE] = dma_done_pulse;
		latch_set[B_RD_DMA_DONE] = i_evt.rd_dma_done;
		latch_set[B_WR_DMA_ERR] = dma_err_pulse;
		latch_set[B_RD_DMA_ERR] = i_evt.rd_dma_err;
		latch_set[B_RX_READY] = i_evt.rx_ready;
		latch_set[B_TX_DREAD] = i_evt.tx_data_read;
		latch_set[B_TX_FDONE] = i_evt.tx_frame_done;
		latch_set[B_RX_FDONE] = i_evt.rx_frame_done;
	end

	// only latched positions can be cleared; zeros written do nothing
	assign latch_clr = wr_status ? (i_reg_wdata & LATCH_MASK) : '0;

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			latch_q <= STATUS_RESET;
		end else begin
			latch_q <= ((latch_q & ~latch_clr) | latch_set) & LATCH_MASK;
		end
	end

	always_comb begin
		status_live = '0;
		status_live[0] = (i_live.tx_count == 14'h0000);
		status_live[1] = tx_ae_now;
		status_live[2] = i_live.tx_full;
		status_live[3] = (i_live.tx_count != 14'h0000) | i_live.tx_stage_valid
			| (buf_cnt_q != 2'h0);
		status_live[4] = (i_live.rx_count == 15'h0000);
		status_live[5] = rx_af_now;
		status_live[6] = i_live.rx_full;
		status_live[7] = (i_live.rx_count != 15'h0000)
			| (i_live.rx_stage_cnt != 3'h0);
		status_live[16] = o_wr_dma_idle;
		status_live[17] = i_live.rd_dma_idle;
		status_live[22] = i_live.rx_running;
		status_live[23] = i_live.rx_io_full;
		status_live[24] = i_live.aux_empty;
		status_live[25] = i_live.aux_afull;
		status_live[26] = i_live.aux_full;
		status_live[27] = i_live.tx_fifo_out_valid;
		status_live[29:28] = clamp_io(i_live.tx_io_cnt);
		status_live[30] = i_live.user_irq;
		status_live[31] = i_live.chan_irq;
	end

	// one combined word so live and latched halves come from one cycle
	assign status_word = status_live | latch_q;

	// every read strobe is answered exactly one cycle later
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
		end
	end

	// read data answers one cycle after the strobe
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= '0;
		end else begin
			if (rd_status) begin
				o_reg_rdata <= status_word;
			end else if (rd_fifo) begin
				// an empty rx FIFO reads as zero rather than stalling
				o_reg_rdata <= i_rx_valid ? i_rx_data : '0;
			end else begin
				o_reg_rdata <= '0;
			end
		end
	end

	assign o_rx_pop = rd_fifo & i_rx_valid;

	// two-entry buffer between the data port and the tx FIFO
	assign o_wr_ready = (buf_cnt_q != BUF_FULL_CNT);
	assign buf_push = wr_fifo;
	assign o_tx_valid = (buf_cnt_q != 2'h0);
	assign buf_pop = o_tx_valid & i_tx_ready;
	assign o_tx_data = buf_mem_q[buf_rd_idx_q];

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			buf_mem_q[0] <= '0;
			buf_mem_q[1] <= '0;
			buf_wr_idx_q <= 1'b0;
			buf_rd_idx_q <= 1'b0;
			buf_cnt_q <= 2'h0;
		end else begin
			if (buf_push) begin
				buf_mem_q[buf_wr_idx_q] <= i_reg_wdata;
				buf_wr_idx_q <= ~buf_wr_idx_q;
			end
			if (buf_pop) begin
				buf_rd_idx_q <= ~buf_rd_idx_q;
			end
			if (buf_push & ~buf_pop) begin
				buf_cnt_q <= buf_cnt_q + 2'h1;
			end else if (buf_pop & ~buf_push) begin
				buf_cnt_q <= buf_cnt_q - 2'h1;
			end
		end
	end

	// block fields are taken as their descriptor words arrive
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_blk_addr <= '0;
			o_blk_len <= '0;
		end else if (o_desc_req & i_desc_ack & ~i_desc_err
			& ~dma_abort) begin
			if (word_idx_q == 2'h0) begin
				o_blk_addr <= i_desc_data;
			end else if (word_idx_q == 2'h1) begin
				o_blk_len <= i_desc_data;
			end
		end
	end

	// input DMA engine
	// a nonzero pointer written while busy is ignored; abort with zero first
	assign dma_start = wr_ptr & (i_reg_wdata != '0)
		& (dma_state_q == DMA_IDLE);
	assign dma_abort = wr_ptr & (i_reg_wdata == '0);
	assign o_wr_dma_idle = (dma_state_q == DMA_IDLE);
	assign o_desc_req = (dma_state_q == DMA_FETCH);
	assign o_blk_req = (dma_state_q == DMA_MOVE);
	assign o_desc_addr = next_ptr_q + {28'h0000000, word_idx_q, 2'h0};

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dma_state_q <= DMA_IDLE;
			word_idx_q <= 2'h0;
			next_ptr_q <= '0;
			last_desc_q <= 1'b0;
			dma_done_pulse <= 1'b0;
			dma_err_pulse <= 1'b0;
		end else begin
			dma_done_pulse <= 1'b0;
			dma_err_pulse <= 1'b0;
			if (dma_abort) begin
				dma_state_q <= DMA_IDLE;
			end else begin
				case (dma_state_q)
				DMA_IDLE: begin
					if (dma_start) begin
						next_ptr_q <= i_reg_wdata & DESC_ADDR_MASK;
						word_idx_q <= 2'h0;
						dma_state_q <= DMA_FETCH;
					end
				end
				DMA_FETCH: begin
					if (i_desc_ack & i_desc_err) begin
						dma_err_pulse <= 1'b1;
						dma_state_q <= DMA_IDLE;
					end else if (i_desc_ack) begin
						if (word_idx_q == 2'h0) begin
							word_idx_q <= 2'h1;
						end else if (word_idx_q == 2'h1) begin
							word_idx_q <= DESC_LAST_WORD;
						end else if (i_desc_data[DESC_DIR_BIT]
							!= DESC_DIR_INPUT) begin
							dma_err_pulse <= 1'b1;
							dma_state_q <= DMA_IDLE;
						end else begin
							last_desc_q <= i_desc_data[DESC_EOC_BIT];
							next_ptr_q <= i_desc_data & DESC_ADDR_MASK;
							word_idx_q <= 2'h0;
							dma_state_q <= DMA_MOVE;
						end
					end
				end
				DMA_MOVE: begin
					if (i_blk_err) begin
						dma_err_pulse <= 1'b1;
						dma_state_q <= DMA_IDLE;
					end else if (i_blk_done & last_desc_q) begin
						dma_done_pulse <= 1'b1;
						dma_state_q <= DMA_IDLE;
					end else if (i_blk_done) begin
						dma_state_q <= DMA_FETCH;
					end
				end
				default: begin
					dma_state_q <= DMA_IDLE;
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// >>> verif/csdp_host_model.sv
/*
 * Host memory model: answers descriptor fetches and block moves.
 * Assumes level requests from the engine, held until each answer pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module csdp_host_model (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_desc_req,
	input wire logic [31:0] i_desc_addr,
	input wire logic i_blk_req,
	output logic o_desc_ack,
	output logic [31:0] o_desc_data,
	output logic o_blk_done
);
	logic [1:0] wait_q;

	// chains at 0x100 -> 0x110 (end), and 0x120 with a bad direction bit
	function automatic logic [31:0] word(input logic [5:0] a);
		case (a)
			6'h00: word = 32'h0000_1000;
			6'h04: word = 32'h0000_0040;
			6'h08: word = 32'h0000_0110;
			6'h10: word = 32'h0000_2000;
			6'h14: word = 32'h0000_0080;
			6'h18: word = 32'h0000_0001;
			6'h28: word = 32'h0000_0003;
			default: word = 32'h0000_0010;
		endcase
	endfunction

	// answers after three cycles so that an abort lands mid-chain
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{wait_q, o_desc_ack, o_blk_done, o_desc_data} <= '0;
		end else begin
			o_desc_ack <= 1'b0;
			o_blk_done <= 1'b0;
			// released bus never keeps the last word
			o_desc_data <= ~o_desc_data;
			wait_q <= 2'h0;
			if ((i_desc_req | i_blk_req) & ~o_desc_ack & ~o_blk_done) begin
				wait_q <= wait_q + 2'h1;
				if (wait_q == 2'h2) begin
					o_desc_ack <= i_desc_req;
					o_blk_done <= ~i_desc_req;
					o_desc_data <= word(i_desc_addr[5:0]);
				end
			end
		end
	end
endmodule

`default_nettype wire

// >>> verif/csdp_channel_regs_asserts.sv
/*
 * Port checker for the channel register block.
 * Assumes the block's clock, reset and register strobes as in the package.
 */
`timescale 1ns/1ps
`default_nettype none

module csdp_channel_regs_asserts
	import csdp_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire csdp_live_t i_live,
	input wire csdp_evt_t i_evt,
	input wire logic i_rx_valid,
	input wire logic [31:0] i_rx_data,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	input wire logic o_rx_pop,
	input wire logic o_desc_req,
	input wire logic [31:0] o_desc_addr,
	input wire logic o_blk_req,
	input wire logic o_wr_dma_idle
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	wire st_rd = i_reg_rd && i_reg_addr == OFS_CHAN_STATUS;
	wire ptr_wr = i_reg_wr && i_reg_addr == OFS_DMA_PTR;
	wire st_clr = i_reg_wr && i_reg_addr == OFS_CHAN_STATUS
		&& i_reg_wdata[B_SYM_ERR];

	read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
		else $error("answer without read");
	tx_full_a: assert property (st_rd |=>
		o_reg_rdata[2] == $past(i_live.tx_full)) else $error("tx full");
	tx_low_a: assert property (st_rd &&
		i_live.tx_count <= i_live.tx_ae_level |=> o_reg_rdata[1])
		else $error("tx low level");
	rx_full_a: assert property (st_rd |=>
		o_reg_rdata[6] == $past(i_live.rx_full)) else $error("rx full");
	chan_irq_a: assert property (st_rd |=>
		o_reg_rdata[31] == $past(i_live.chan_irq)) else $error("irq bit");
	user_irq_a: assert property (st_rd |=>
		o_reg_rdata[30] == $past(i_live.user_irq)) else $error("user irq");
	io_clamp_a: assert property (st_rd && i_live.tx_io_cnt == 2'h3
		|=> o_reg_rdata[29:28] == TX_IO_MAX) else $error("io clamp");
	idle_bit_a: assert property (st_rd |=>
		o_reg_rdata[16] == $past(o_wr_dma_idle)) else $error("idle bit");
	rx_pop_a: assert property (i_reg_rd && i_reg_addr == OFS_FIFO_DATA
		&& i_rx_valid |-> o_rx_pop ##1 o_reg_rdata == $past(i_rx_data))
		else $error("rx pop");
	dma_start_a: assert property (ptr_wr && i_reg_wdata != 32'h0
		&& o_wr_dma_idle |=> o_desc_req
		&& o_desc_addr == ($past(i_reg_wdata) & DESC_ADDR_MASK))
		else $error("dma start");
	dma_abort_a: assert property (ptr_wr && i_reg_wdata == 32'h0
		|=> o_wr_dma_idle && !o_desc_req && !o_blk_req)
		else $error("dma abort");
	busy_flag_a: assert property ((o_desc_req || o_blk_req)
		|-> !o_wr_dma_idle) else $error("busy idle");
	sym_latch_a: assert property (i_evt.rx_viol
		##1 (!st_clr)[*3] ##1 st_rd |=> o_reg_rdata[B_SYM_ERR])
		else $error("symbol latch");
endmodule

bind csdp_channel_regs csdp_channel_regs_asserts u_csdp_channel_regs_asserts (
	.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n),
	.i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd),
	.i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata),
	.i_live(i_live),
	.i_evt(i_evt),
	.i_rx_valid(i_rx_valid),
	.i_rx_data(i_rx_data),
	.o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid),
	.o_rx_pop(o_rx_pop),
	.o_desc_req(o_desc_req),
	.o_desc_addr(o_desc_addr),
	.o_blk_req(o_blk_req),
	.o_wr_dma_idle(o_wr_dma_idle)
);

`default_nettype wire

// >>> verif/tb_csdp_channel_regs.sv
/*
 * Self-checking bench for the channel register block and host model.
 * Assumes 40 MHz clock; inputs change on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_csdp_channel_regs
	import csdp_pkg::*;
();
	localparam logic [31:0] BASE = 32'h0003_0088;
	logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic [ADDR_W-1:0] i_reg_addr = 9'h000;
	logic [31:0] i_reg_wdata = 32'h0, i_rx_data = 32'h0, rd_q;
	logic i_tx_ready = 1'b0, i_rx_valid = 1'b0;
	logic i_desc_err = 1'b0, i_blk_err = 1'b0, i_desc_ack, i_blk_done;
	logic [31:0] o_reg_rdata, o_tx_data, o_desc_addr, i_desc_data;
	logic [31:0] o_blk_addr, o_blk_len;
	logic o_reg_rvalid, o_wr_ready, o_tx_valid, o_rx_pop;
	logic o_desc_req, o_blk_req, o_wr_dma_idle;
	csdp_live_t i_live;
	csdp_evt_t i_evt = 8'h00;
	int failures = 0, samples_checked = 0;

	csdp_channel_regs u_csdp_channel_regs (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
		.o_wr_ready(o_wr_ready), .i_live(i_live), .i_evt(i_evt),
		.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
		.i_tx_ready(i_tx_ready), .i_rx_valid(i_rx_valid),
		.i_rx_data(i_rx_data), .o_rx_pop(o_rx_pop),
		.o_desc_req(o_desc_req), .o_desc_addr(o_desc_addr),
		.i_desc_ack(i_desc_ack), .i_desc_data(i_desc_data),
		.i_desc_err(i_desc_err), .o_blk_req(o_blk_req),
		.o_blk_addr(o_blk_addr), .o_blk_len(o_blk_len),
		.i_blk_done(i_blk_done), .i_blk_err(i_blk_err),
		.o_wr_dma_idle(o_wr_dma_idle));
	csdp_host_model u_csdp_host_model (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_desc_req(o_desc_req),
		.i_desc_addr(o_desc_addr), .i_blk_req(o_blk_req),
		.o_desc_ack(i_desc_ack), .o_desc_data(i_desc_data),
		.o_blk_done(i_blk_done));

	always #12.5 i_clk_sys = ~i_clk_sys;

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk32({31'h0, g}, {31'h0, e});
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(negedge i_clk_sys);
		{i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
		@(negedge i_clk_sys);
		i_reg_wr = 1'b0;
	endtask
	// answer comes exactly one cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(negedge i_clk_sys);
		{i_reg_rd, i_reg_addr} = {1'b1, a};
		@(negedge i_clk_sys);
		i_reg_rd = 1'b0;
		chk1(o_reg_rvalid, 1'b1);
		rd_q = o_reg_rdata;
	endtask
	task automatic poll(input int b);
		for (int n = 0; n < 60; n++) begin
			rd(OFS_CHAN_STATUS);
			if (rd_q[b] === 1'b1) return;
		end
		failures++;
		$display("[ERR] %0t status bit %0d never set", $time, b);
		end_of_test();
	endtask
	// thresholds kept away from the counts so no level flag is live
	task automatic live0;
		i_live = '0;
		i_live.tx_count = 14'h0005;
		i_live.tx_ae_level = 14'h0002;
		i_live.rx_count = 15'h0001;
		i_live.rx_af_level = 15'h000A;
		i_live.rd_dma_idle = 1'b1;
	endtask

	task automatic t_reset;
		rd(OFS_CHAN_STATUS);
		chk32(rd_q, BASE);
		rd(9'h1F0);
		chk32(rd_q, 32'h0);
		rd(OFS_DMA_PTR);
		chk32(rd_q, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_events;
		int bits [8] = '{11, 18, 19, 20, 21, 10, 13, 15};
		for (int k = 0; k < 8; k++) begin
			@(negedge i_clk_sys);
			i_live.rx_full = (k == 5);
			i_evt = 8'h80 >> k;
			@(negedge i_clk_sys);
			i_evt = 8'h00;
			i_live.rx_full = 1'b0;
			wr(OFS_CHAN_STATUS, 32'h0);
			rd(OFS_CHAN_STATUS);
			chk32(rd_q, BASE | (32'h1 << bits[k]));
			wr(OFS_CHAN_STATUS, 32'hFFFF_FFFF);
			rd(OFS_CHAN_STATUS);
			chk32(rd_q, BASE);
		end
		i_live.tx_count = 14'h0002;
		i_live.rx_count = 15'h000A;
		rd(OFS_CHAN_STATUS);
		chk32(rd_q, BASE | 32'h0000_0322);
		live0();
		rd(OFS_CHAN_STATUS);
		chk32(rd_q, BASE | 32'h0000_0300);
		wr(OFS_CHAN_STATUS, 32'h0000_0300);
		rd(OFS_CHAN_STATUS);
		chk32(rd_q, BASE);
		$display("t_events done");
	endtask
	task automatic t_live;
		i_live.tx_full = 1'b1;
		i_live.tx_fifo_out_valid = 1'b1;
		i_live.tx_io_cnt = 2'h3;
		i_live.rx_count = 15'h0000;
		i_live.rx_stage_cnt = 3'h3;
		i_live.rx_running = 1'b1;
		i_live.rx_io_full = 1'b1;
		i_live.rd_dma_idle = 1'b0;
		i_live.user_irq = 1'b1;
		i_live.chan_irq = 1'b1;
		rd(OFS_CHAN_STATUS);
		chk32(rd_q, 32'hE8C1_009C);
		live0();
		i_live.tx_count = 14'h0000;
		i_live.tx_stage_valid = 1'b1;
		rd(OFS_CHAN_STATUS);
		chk32(rd_q, BASE | 32'h0000_0103);
		wr(OFS_CHAN_STATUS, 32'h0000_0100);
		live0();
		rd(OFS_CHAN_STATUS);
		chk32(rd_q, BASE);
		$display("t_live done");
	endtask
	task automatic t_fifo;
		wr(OFS_FIFO_DATA, 32'hA5A5_0001);
		wr(OFS_FIFO_DATA, 32'hA5A5_0002);
		chk1(o_wr_ready, 1'b0);
		wr(OFS_FIFO_DATA, 32'hDEAD_BEEF);
		chk32(o_tx_data, 32'hA5A5_0001);
		i_tx_ready = 1'b1;
		@(negedge i_clk_sys);
		chk32(o_tx_data, 32'hA5A5_0002);
		@(negedge i_clk_sys);
		chk1(o_tx_valid, 1'b0);
		i_tx_ready = 1'b0;
		i_rx_valid = 1'b1;
		i_rx_data = 32'h1234_5678;
		rd(OFS_FIFO_DATA);
		chk32(rd_q, 32'h1234_5678);
		i_rx_valid = 1'b0;
		rd(OFS_FIFO_DATA);
		chk32(rd_q, 32'h0);
		$display("t_fifo done");
	endtask
	task automatic t_dma;
		wr(OFS_DMA_PTR, 32'h0000_0100);
		chk1(o_wr_dma_idle, 1'b0);
		poll(B_WR_DMA_DONE);
		chk32(rd_q & 32'h0001_5000, 32'h0001_1000);
		chk32(o_blk_addr, 32'h0000_2000);
		chk32(o_blk_len, 32'h0000_0080);
		wr(OFS_CHAN_STATUS, 32'h0000_1000);
		wr(OFS_DMA_PTR, 32'h0000_0120);
		poll(B_WR_DMA_ERR);
		chk1(rd_q[B_WR_DMA_DONE], 1'b0);
		wr(OFS_CHAN_STATUS, 32'h0000_4000);
		wr(OFS_DMA_PTR, 32'h0000_0100);
		for (int n = 0; n < 40 && o_blk_req !== 1'b1; n++) begin
			@(negedge i_clk_sys);
		end
		chk1(o_blk_req, 1'b1);
		if (o_blk_req !== 1'b1) end_of_test();
		i_blk_err = 1'b1;
		@(negedge i_clk_sys);
		i_blk_err = 1'b0;
		chk1(o_wr_dma_idle, 1'b1);
		poll(B_WR_DMA_ERR);
		chk1(rd_q[B_WR_DMA_DONE], 1'b0);
		wr(OFS_CHAN_STATUS, 32'h0000_4000);
		wr(OFS_DMA_PTR, 32'h0000_0100);
		wr(OFS_DMA_PTR, 32'h0);
		chk1(o_wr_dma_idle, 1'b1);
		repeat (8) @(negedge i_clk_sys);
		rd(OFS_CHAN_STATUS);
		chk32(rd_q & 32'h0000_5000, 32'h0);
		$display("t_dma done");
	endtask

	initial begin
		live0();
		repeat (12) @(negedge i_clk_sys);
		i_rst_n = 1'b1;
		t_reset();
		t_events();
		t_live();
		t_fifo();
		t_dma();
		end_of_test();
	end
endmodule

`default_nettype wire
